// >>> verilog/ssp_cfg.svh
// constants of the status and protection block
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ****************************************
// command codes, msb first on the wire
// ****************************************
`define SSP_CMD_WRITE_ENABLE  8'h06
`define SSP_CMD_WRITE_DISABLE 8'h04
`define SSP_CMD_READ_STATUS   8'h05
`define SSP_CMD_WRITE_STATUS  8'h01
`define SSP_CMD_READ_CODE     8'h03
`define SSP_CMD_WRITE_CODE    8'h02

// ****************************************
// status byte field positions
// ****************************************
`define SSP_BIT_LOCK 7
`define SSP_BIT_BPHI 3
`define SSP_BIT_BPLO 2
`define SSP_BIT_LATCH 1
`define SSP_BIT_BUSY 0

// ****************************************
// protected range lower bounds, delivery state
// ****************************************
`define SSP_ADDR_W       13
`define SSP_PROT_QUARTER 13'h1800
`define SSP_PROT_HALF    13'h1000
`define SSP_NV_DELIVERY  1'b0

// ****************************************
// timing
// ****************************************
`define SSP_MCLK_MHZ   20
`define SSP_SELF_WRITE_US     5000
`define SSP_SELF_WRITE_CYCLES (`SSP_SELF_WRITE_US * `SSP_MCLK_MHZ)
`define SSP_TIMER_W    20

`endif

// >>> verilog/ssp_pkg.sv
// types of the status and protection block
package ssp_pkg;

    // frame states, gray along command, data, end
    typedef enum logic [2:0] {
        SSP_IDLE = 3'h0,
        SSP_CMD  = 3'h1,
        SSP_DATA = 3'h3,
        SSP_END  = 3'h2,
        SSP_WAIT = 3'h6,
        SSP_POLL = 3'h7,
        SSP_IGN  = 3'h5
    } ssp_state_t;

    // serial pins as seen by the device
    typedef struct packed {
        logic chipSelN;
        logic serialClk;
        logic dataIn;
        logic writeProtN;
    } ssp_pins_t;

    // status byte layout
    typedef struct packed {
        logic       statusWriteLock;
        logic [2:0] zeroBits;
        logic       blockProtectHi;
        logic       blockProtectLo;
        logic       writeEnableLatch;
        logic       writeBusyFlag;
    } ssp_status_t;

endpackage

// >>> verilog/ssp_status_protect.sv
// status byte and write protection of a serial eeprom
// Overview of operation
// - write disable clears the enable latch
// - command byte shifted, status read acted on at once, others at deselect
// - latch cleared by reset, disable, write ends
// - status read accepted even while busy
// - status byte repeats while select stays low
// - busy high during any write cycle
// - latch clear rejects array and status writes
// - block protect nonvolatile, refuses protected writes
// - block protect changes only outside hardware mode
// - lock plus low protect pin refuses status writes
// - status write needs latch set first
// - deselect exactly after data byte, else discard
// - deselect starts timed cycle and busy, latch clears when it ends
// - new protect bits land after cycle ends
// - bits six to four read zero
// - lock clear allows status write any pin
// - lock set obeys protect pin level
// - hardware mode entered in either order
// - only high protect pin leaves hardware mode
// - command codes, unknown code deselects device
// - block protect pair selects protected range
// - only write enable sets the latch
// - power up clears busy, latch, keeps nonvolatile; here they survive reset only, power-on loads the delivery state
`timescale 1ns/10ps
`include "ssp_cfg.svh"

module ssp_status_protect
    import ssp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SSP_SELF_WRITE_CYCLES
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    // serial pins
    input  wire ssp_pins_t              pinIn,
    output logic                        dataOut,
    output logic                        dataOutEnN,
    // array write sequencer
    input  wire logic                   arrayWriteReq,
    input  wire logic [`SSP_ADDR_W-1:0] arrayAddr,
    output logic                        arrayProtected,
    output logic                        arrayWriteGo,
    // status view
    output ssp_status_t                 statusByte,
    output logic                        hwProtectedMode
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    ssp_pins_t pinS1;
    ssp_pins_t pinS2;
    logic      csPrev;
    logic      clkPrev;

    // two stages; edges are taken from stage two only
    always_ff @(posedge mclk) begin
        pinS1   <= pinIn;
        pinS2   <= pinS1;
        csPrev  <= pinS2.chipSelN;
        clkPrev <= pinS2.serialClk;
    end

    logic sclkRise;
    logic sclkFall;
    logic csRise;
    assign sclkRise = pinS2.serialClk & ~clkPrev;
    assign sclkFall = ~pinS2.serialClk & clkPrev;
    assign csRise   = pinS2.chipSelN & ~csPrev;

    // ****************************************
    // frame decoding
    // ****************************************
    ssp_state_t phase;
    logic       armed;
    logic [2:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] cmdByte;
    logic [7:0] next_byte;
    logic       selected;

    assign next_byte = {shiftIn[6:0], pinS2.dataIn};
    assign selected  = armed & ~pinS2.chipSelN;

    // selection needs chip select seen high first after power up
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (pinS2.chipSelN) begin
            armed <= 1'b1;
        end
    end

    // shift in command and data on the serial clock rise
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            phase   <= SSP_IDLE;
            bitCnt  <= 3'h0;
            shiftIn <= 8'h00;
            cmdByte <= 8'h00;
        end else if (!selected) begin
            phase  <= SSP_IDLE;
            bitCnt <= 3'h0;
        end else if (sclkRise) begin
            case (phase)
                SSP_IDLE, SSP_CMD: begin
                    shiftIn <= next_byte;
                    bitCnt  <= bitCnt + 3'h1;
                    phase   <= SSP_CMD;
                    if (bitCnt == 3'h7) begin
                        cmdByte <= next_byte;
                        case (next_byte)
                            `SSP_CMD_WRITE_ENABLE:  phase <= SSP_WAIT;
                            `SSP_CMD_WRITE_DISABLE: phase <= SSP_WAIT;
                            `SSP_CMD_READ_STATUS:   phase <= SSP_POLL;
                            `SSP_CMD_WRITE_STATUS:  phase <= SSP_DATA;
                            default:                phase <= SSP_IGN;
                        endcase
                    end
                end
                SSP_DATA: begin
                    shiftIn <= next_byte;
                    bitCnt  <= bitCnt + 3'h1;
                    if (bitCnt == 3'h7) begin
                        phase <= SSP_END;
                    end
                end
                // any clock past the byte boundary discards the command
                SSP_WAIT, SSP_END: phase <= SSP_IGN;
                SSP_POLL: phase <= SSP_POLL;
                default:  phase <= SSP_IGN;
            endcase
        end
    end

    // ****************************************
    // write cycle and enable latch
    // ****************************************
    logic                    busy;
    logic                    enLatch;
    logic                    statusCycle;
    logic [`SSP_TIMER_W-1:0] timer;
    logic [7:0]              pendByte;
    // delivery state as power-on value; one writer only, so no initial process
    // limitation: a real part keeps these across power cycles, here only across reset
    logic                    nvLock = `SSP_NV_DELIVERY;
    logic [1:0]              nvBp   = {2{`SSP_NV_DELIVERY}};
    logic                    statusWrStart;
    logic                    cycleEnd;
    logic                    commitNv;
    logic                    execCmd;

    // lock with a low pin protects, pin high releases at once
    assign hwProtectedMode = nvLock & ~pinS2.writeProtN;
    assign execCmd       = csRise & (phase == SSP_WAIT);
    // refused silently while busy, latch clear or hardware mode
    assign statusWrStart = csRise & (phase == SSP_END) & enLatch & ~busy
                         & ~hwProtectedMode;
    assign cycleEnd  = busy & (timer == `SSP_TIMER_W'(1));
    assign commitNv  = cycleEnd & statusCycle;

    // protected range from the block protect pair
    always_comb begin
        case (nvBp)
            2'b01:   arrayProtected = (arrayAddr >= `SSP_PROT_QUARTER);
            2'b10:   arrayProtected = (arrayAddr >= `SSP_PROT_HALF);
            2'b11:   arrayProtected = 1'b1;
            default: arrayProtected = 1'b0;
        endcase
    end

    // a status write wins a tie, the array side retries
    assign arrayWriteGo = arrayWriteReq & enLatch & ~busy & ~arrayProtected
                        & ~statusWrStart;

    // busy timer, one cycle of either kind at a time
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            busy        <= 1'b0;
            timer       <= '0;
            statusCycle <= 1'b0;
            pendByte    <= 8'h00;
        end else if (statusWrStart) begin
            busy        <= 1'b1;
            timer       <= `SSP_TIMER_W'(WRITE_CYCLES);
            statusCycle <= 1'b1;
            pendByte    <= shiftIn;
        end else if (arrayWriteGo) begin
            busy        <= 1'b1;
            timer       <= `SSP_TIMER_W'(WRITE_CYCLES);
            statusCycle <= 1'b0;
        end else if (busy) begin
            timer <= timer - `SSP_TIMER_W'(1);
            if (cycleEnd) begin
                busy <= 1'b0;
            end
        end
    end

    // enable latch; a set lands after clears in the same cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            enLatch <= 1'b0;
        end else begin
            if (cycleEnd) begin
                enLatch <= 1'b0;
            end
            if (execCmd && cmdByte == `SSP_CMD_WRITE_DISABLE) begin
                enLatch <= 1'b0;
            end
            if (execCmd && cmdByte == `SSP_CMD_WRITE_ENABLE) begin
                enLatch <= 1'b1;
            end
        end
    end

    // nonvolatile bits survive reset, loaded only at cycle end
    always_ff @(posedge mclk) begin
        if (commitNv) begin
            nvLock <= pendByte[`SSP_BIT_LOCK];
            nvBp   <= {pendByte[`SSP_BIT_BPHI], pendByte[`SSP_BIT_BPLO]};
        end
    end

    // ****************************************
    // status byte and serial output
    // ****************************************
    // other bits of the written byte are never stored
    assign statusByte = '{statusWriteLock:  nvLock,
                          zeroBits:         3'h0,
                          blockProtectHi:   nvBp[1],
                          blockProtectLo:   nvBp[0],
                          writeEnableLatch: enLatch,
                          writeBusyFlag:    busy};

    logic [2:0] outIdx;
    logic [7:0] outShift;

    // a fresh snapshot at each byte start keeps polling current
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dataOut    <= 1'b0;
            dataOutEnN <= 1'b1;
            outIdx     <= 3'h0;
            outShift   <= 8'h00;
        end else if (phase != SSP_POLL || !selected) begin
            dataOutEnN <= 1'b1;
            outIdx     <= 3'h0;
        end else if (sclkFall) begin
            dataOutEnN <= 1'b0;
            outIdx     <= outIdx + 3'h1;
            if (outIdx == 3'h0) begin
                dataOut  <= statusByte[7];
                outShift <= {statusByte[6:0], 1'b0};
            end else begin
                dataOut  <= outShift[7];
                outShift <= {outShift[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_disable_clears_latch: assert property (execCmd && cmdByte == `SSP_CMD_WRITE_DISABLE |=> !enLatch)
        else $error("latch still set after write disable");
    // a write enable landing on the last cycle legally wins
    a_cycle_end_latch: assert property (cycleEnd && !execCmd |=> !enLatch && !busy)
        else $error("latch or busy left set after write cycle");
    a_busy_holds: assert property ($rose(busy) |-> busy[*4])
        else $error("busy dropped early");
    a_latch_needed: assert property ($rose(busy) |-> $past(enLatch))
        else $error("write cycle started without latch");
    a_protected_refused: assert property (arrayProtected |-> !arrayWriteGo)
        else $error("protected array write let through");
    a_hw_mode_refuses: assert property (csRise && phase == SSP_END && hwProtectedMode
        && !busy && !arrayWriteGo |=> !busy)
        else $error("status write accepted in hardware mode");
    a_unlocked_accepts: assert property (csRise && phase == SSP_END
        && enLatch && !busy && !nvLock |=> busy)
        else $error("status write refused with lock clear");
    a_nv_stable: assert property (busy && !cycleEnd |=> $stable(nvBp) && $stable(nvLock))
        else $error("protect bits changed mid cycle");
    a_commit_after_cycle: assert property ($changed(nvLock) || $changed(nvBp) |-> $past(commitNv))
        else $error("protect bits changed outside a cycle end");
    a_status_read_any: assert property (selected && sclkRise && phase == SSP_CMD && bitCnt == 3'h7
        && next_byte == `SSP_CMD_READ_STATUS |=> phase == SSP_POLL)
        else $error("status read not entered");
    a_extra_clock_discard: assert property (selected && sclkRise && phase == SSP_END |=> phase == SSP_IGN)
        else $error("late clock did not discard status write");
    a_write_start_busy: assert property (statusWrStart |=> busy && statusCycle)
        else $error("status write did not start a cycle");
    a_unknown_no_drive: assert property (phase == SSP_IGN |=> dataOutEnN)
        else $error("output driven after unknown command");
    a_poll_released: assert property (!selected |=> dataOutEnN)
        else $error("output still driven while deselected");

endmodule

// >>> tb/ssp_host_model.sv
// serial host model driving the status block pins
`timescale 1ns/10ps

module ssp_host_model (
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      csN,
    output logic      sclk,
    output logic      sdi,
    input  wire logic dataOut,
    input  wire logic dataOutEnN
);
    // deselected and clock parked low outside frames
    initial begin
        csN  = 1'h1;
        sclk = 1'h0;
        sdi  = 1'h0;
    end

    // one frame, nb bits msb first; released output reads as unknown
    task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx, output logic drv);
        rx  = '0;
        drv = 1'h0;
        @(negedge mclk) csN = 1'h0;
        repeat (4) @(negedge mclk);
        for (int i = nb - 1; i >= 0; i--) begin
            sdi = tx[i];
            repeat (4) @(negedge mclk);
            sclk = 1'h1;
            repeat (4) @(negedge mclk);
            // sampled just before the fall, where the bit is settled
            rx   = {rx[22:0], (dataOutEnN === 1'h0) ? dataOut : 1'hx};
            drv  = drv | (dataOutEnN === 1'h0);
            sclk = 1'h0;
        end
        repeat (4) @(negedge mclk);
        csN = 1'h1;
        sdi = ~sdi;
        repeat (8) @(negedge mclk);
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the status and protection block
`timescale 1ns/10ps
`include "ssp_cfg.svh"

module tb_top import ssp_pkg::*; ();
    // short self-timed cycle, still longer than a two-byte status poll
    localparam int unsigned SELF_CYCLES = 400;

    logic                   mclk          = 1'h0;
    logic                   nrst          = 1'h0;
    logic                   wpN           = 1'h1;
    logic                   arrayWriteReq = 1'h0;
    logic [`SSP_ADDR_W-1:0] arrayAddr     = '0;
    logic                   csN;
    logic                   sclk;
    logic                   sdi;
    logic                   dataOut;
    logic                   dataOutEnN;
    logic                   arrayProtected;
    logic                   arrayWriteGo;
    logic                   hwProtectedMode;
    ssp_status_t            statusByte;
    ssp_pins_t              pins;
    logic [23:0]            rx;
    logic                   drv;
    logic [`SSP_ADDR_W-1:0] addrs [6] = '{13'h0000, 13'h0FFF, 13'h1000, 13'h17FF, 13'h1800, 13'h1FFF};
    int                     errors    = 0;
    int                     nCompared = 0;

    always #25 mclk = ~mclk;
    assign pins = {csN, sclk, sdi, wpN};

    ssp_status_protect #(.WRITE_CYCLES(SELF_CYCLES)) dut (
        .mclk(mclk), .nrst(nrst), .pinIn(pins), .dataOut(dataOut), .dataOutEnN(dataOutEnN),
        .arrayWriteReq(arrayWriteReq), .arrayAddr(arrayAddr), .arrayProtected(arrayProtected),
        .arrayWriteGo(arrayWriteGo), .statusByte(statusByte), .hwProtectedMode(hwProtectedMode));
    ssp_host_model host (.mclk(mclk), .csN(csN), .sclk(sclk), .sdi(sdi), .dataOut(dataOut),
        .dataOutEnN(dataOutEnN));

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim();
        if (errors == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded poll of busy; a stuck cycle ends the run
    task automatic wait_idle();
        int n;
        n = 0;
        while (statusByte.writeBusyFlag !== 1'h0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 1000) begin
            errors++;
            $display("ERROR %0t: busy never cleared", $time);
            end_sim();
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        host.xfer({16'h0, c}, 8, rx, drv);
    endtask

    task automatic write_status(input logic [7:0] d);
        cmd(`SSP_CMD_WRITE_ENABLE);
        host.xfer({8'h0, `SSP_CMD_WRITE_STATUS, d}, 16, rx, drv);
        wait_idle();
    endtask

    task automatic read_status();
        host.xfer({`SSP_CMD_READ_STATUS, 16'h0}, 24, rx, drv);
    endtask

    task automatic pulse(input logic [12:0] a, input logic exp);
        @(negedge mclk);
        arrayAddr     = a;
        arrayWriteReq = 1'h1;
        #1 chk(arrayWriteGo, exp);
        @(negedge mclk);
        arrayWriteReq = 1'h0;
    endtask

    function automatic logic prot(input int b, input logic [12:0] a);
        return (b == 3) || (b == 2 && a >= 13'h1000) || (b == 1 && a >= 13'h1800);
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(negedge mclk);
        nrst = 1'h1;
        repeat (5) @(negedge mclk);
        chk(statusByte, 16'h00);
        read_status();
        chk(rx[15:0], 16'h0000);
        cmd(`SSP_CMD_WRITE_ENABLE);
        read_status();
        chk(rx[15:0], 16'h0202);
        cmd(`SSP_CMD_WRITE_DISABLE);
        chk(statusByte, 16'h00);
        // status write without the latch is dropped
        host.xfer({8'h0, `SSP_CMD_WRITE_STATUS, 8'h8C}, 16, rx, drv);
        chk(statusByte, 16'h00);
        // new bits wait for the end of the cycle, poll while busy
        cmd(`SSP_CMD_WRITE_ENABLE);
        host.xfer({8'h0, `SSP_CMD_WRITE_STATUS, 8'hFF}, 16, rx, drv);
        chk(statusByte, 16'h03);
        read_status();
        chk(rx[15:0], 16'h0303);
        wait_idle();
        chk(statusByte, 16'h8C);
        // lock set first, then protect pin low
        wpN = 1'h0;
        repeat (4) @(negedge mclk);
        chk(hwProtectedMode, 16'h1);
        cmd(`SSP_CMD_WRITE_ENABLE);
        host.xfer({8'h0, `SSP_CMD_WRITE_STATUS, 8'h00}, 16, rx, drv);
        chk(statusByte, 16'h8E);
        // reset in mid run drops the latch, keeps the stored bits
        nrst = 1'h0;
        repeat (2) @(negedge mclk);
        nrst = 1'h1;
        repeat (5) @(negedge mclk);
        chk(statusByte, 16'h8C);
        chk(hwProtectedMode, 16'h1);
        wpN = 1'h1;
        repeat (4) @(negedge mclk);
        chk(hwProtectedMode, 16'h0);
        write_status(8'h00);
        chk(statusByte, 16'h00);
        // pin low first, then lock set
        wpN = 1'h0;
        repeat (4) @(negedge mclk);
        write_status(8'h80);
        chk(statusByte, 16'h80);
        chk(hwProtectedMode, 16'h1);
        wpN = 1'h1;
        write_status(8'h00);
        // one clock rise too many after the data byte
        cmd(`SSP_CMD_WRITE_ENABLE);
        host.xfer({7'h0, `SSP_CMD_WRITE_STATUS, 8'h0C, 1'h0}, 17, rx, drv);
        chk(statusByte, 16'h02);
        cmd(`SSP_CMD_WRITE_DISABLE);
        host.xfer({8'hAB, 16'h0}, 24, rx, drv);
        chk(drv, 16'h0);
        // every protect pair against range edges
        for (int b = 0; b < 4; b++) begin
            write_status({4'h0, b[1:0], 2'h0});
            chk(statusByte, {12'h0, b[1:0], 2'h0});
            foreach (addrs[k]) begin
                @(negedge mclk) arrayAddr = addrs[k];
                #1 chk(arrayProtected, prot(b, addrs[k]));
            end
        end
        cmd(`SSP_CMD_WRITE_ENABLE);
        pulse(13'h0000, 1'h0);
        write_status(8'h00);
        pulse(13'h0000, 1'h0);
        cmd(`SSP_CMD_WRITE_ENABLE);
        pulse(13'h0000, 1'h1);
        chk(statusByte.writeBusyFlag, 16'h1);
        wait_idle();
        chk(statusByte, 16'h00);
        end_sim();
    end
endmodule
